// file: rtl/lbs_pkg.sv
// Constants and types shared by the lamp ballast sequencer
`default_nettype none
package lbs_pkg;
  typedef enum logic [7:0] {
    ST_STARTUP   = 8'h01,
    ST_PREHEAT   = 8'h02,
    ST_IGNITE    = 8'h04,
    ST_BOOST     = 8'h08,
    ST_TRANS     = 8'h10,
    ST_BURN      = 8'h20,
    ST_HOLD      = 8'h40,
    ST_PWRDN     = 8'h80
  } lbs_state_e;
  localparam int PREHEAT_PULSES  = 8;
  localparam int IGNITE_PULSES   = 2;
  localparam int MAX_ATTEMPTS    = 2;
  localparam int BOOST_PULSES    = 63;
  localparam int TRANS_PULSES    = 32;
  localparam int TRANS_STEPS     = 15;
  // Set points in tenths of nominal: 15 means 1.5, 10 means 1.0
  localparam logic [4:0] RATIO_BOOST = 5'h0F;
  localparam logic [4:0] RATIO_BURN  = 5'h0A;
  // Bridge frequency ratios in tenths: max/min and max/boost-min
  localparam logic [5:0] FRATIO_MIN  = 6'h19;
  localparam logic [5:0] FRATIO_BST  = 6'h2E;
  localparam logic [5:0] FRATIO_NOBST = 6'h1A;
  localparam real T_NO_NS = 1000.0;
  localparam real CLK_NS  = 8.0;
  localparam int  NO_CYC  = (T_NO_NS / CLK_NS) < 1.0 ? 1 : int'(T_NO_NS / CLK_NS - 0.5);
endpackage
`default_nettype wire

// file: rtl/lbs_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module lbs_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge clk)
      begin
        if (srst)
        begin
          s1_q[i] <= 1'b0;
          s2_q[i] <= 1'b0;
          s3_q[i] <= 1'b0;
          dout[i] <= 1'b0;
        end
        else
        begin
          s1_q[i] <= din[i];
          s2_q[i] <= s1_q[i];
          s3_q[i] <= s2_q[i];
          // A change counts only once stages two and three agree
          if (s2_q[i] == s3_q[i])
            dout[i] <= s3_q[i];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// file: rtl/lbs_seq.sv
// Lamp ballast state sequencer with gate drive
`timescale 1ns/1ps
`default_nettype none
module lbs_seq #(
  parameter int NO_CYCLES = lbs_pkg::NO_CYC
) (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       vdd_start_ok,
  input  wire logic       vdd_stop_low,
  input  wire logic       dim_start_ok,
  input  wire logic       dim_off_low,
  input  wire logic       dim_boost_ok,
  input  wire logic       dim_boost_low,
  input  wire logic       preheat_cap_max,
  input  wire logic       preheat_cap_pulse,
  input  wire logic       preheat_cap_top,
  input  wire logic       hold_release_level,
  input  wire logic       boost_cap_pulse,
  input  wire logic       boost_cap_short,
  input  wire logic       lamp_ignited,
  input  wire logic       boost_bypass_temp,
  input  wire logic       boost_end_temp,
  input  wire logic       lamp_rms_at_ref,
  input  wire logic       osc_saw_pulse,
  output logic            high_side_switch,
  output logic            low_side_switch,
  output logic            osc_run,
  output logic            ignite_sweep,
  output logic            transconductance_amp_en,
  output logic [4:0]      current_ratio,
  output logic [5:0]      freq_ratio,
  output logic            hold_latch,
  output logic [7:0]      state_out
);
  ////////////////////////////////////////////////////////////////////////////
  localparam int NIN = 17;
  logic [NIN-1:0] raw;
  logic [NIN-1:0] syn;
  assign raw = {vdd_start_ok, vdd_stop_low, dim_start_ok, dim_off_low, dim_boost_ok,
                dim_boost_low, preheat_cap_max, preheat_cap_pulse, preheat_cap_top,
                hold_release_level, boost_cap_pulse, boost_cap_short, lamp_ignited,
                boost_bypass_temp, boost_end_temp, lamp_rms_at_ref, osc_saw_pulse};

  lbs_sync #(.W(NIN)) u_sync (
    .clk  (clk),
    .srst (srst),
    .din  (raw),
    .dout (syn)
  );

  logic s_vst, s_vsp, s_dst, s_doff, s_dbok, s_dblo, s_pmax, s_ppl, s_ptop;
  logic s_rel, s_bpl, s_bsh, s_ign, s_tbp, s_tend, s_rms, s_osc;
  assign {s_vst, s_vsp, s_dst, s_doff, s_dbok, s_dblo, s_pmax, s_ppl, s_ptop,
          s_rel, s_bpl, s_bsh, s_ign, s_tbp, s_tend, s_rms, s_osc} = syn;

  // Pulses arrive as levels; count rising edges only
  logic ppl_q, bpl_q, osc_q;
  logic p_ev, b_ev, o_ev;
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ppl_q <= 1'b0;
      bpl_q <= 1'b0;
      osc_q <= 1'b0;
    end
    else
    begin
      ppl_q <= s_ppl;
      bpl_q <= s_bpl;
      osc_q <= s_osc;
    end
  end
  assign p_ev = s_ppl & ~ppl_q;
  assign b_ev = s_bpl & ~bpl_q;
  assign o_ev = s_osc & ~osc_q;

  ////////////////////////////////////////////////////////////////////////////
  lbs_pkg::lbs_state_e state_q;
  lbs_pkg::lbs_state_e state_d;
  logic [5:0] pcnt_q;
  logic [5:0] bcnt_q;
  logic [1:0] att_q;
  logic       boost_dis_q;
  logic       boost_act_q;
  logic       wait_top_q;
  logic       abort;
  logic       unlit_tmo;
  logic       fail_ign;

  assign abort     = s_vsp | s_doff;
  assign unlit_tmo = (state_q == lbs_pkg::ST_IGNITE) && p_ev && !s_ign
                     && (pcnt_q == 6'(lbs_pkg::IGNITE_PULSES - 1));
  assign fail_ign  = unlit_tmo && (att_q < 2'(lbs_pkg::MAX_ATTEMPTS - 1));

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      lbs_pkg::ST_STARTUP:
        if (s_vst && s_dst && s_pmax)
          state_d = lbs_pkg::ST_PREHEAT;
      lbs_pkg::ST_PREHEAT:
        if (abort)
          state_d = lbs_pkg::ST_HOLD;
        else if (p_ev && pcnt_q == 6'(lbs_pkg::PREHEAT_PULSES - 1))
          state_d = lbs_pkg::ST_IGNITE;
      lbs_pkg::ST_IGNITE:
        if (abort)
          state_d = lbs_pkg::ST_HOLD;
        else if (s_ign)
        begin
          if (s_tbp || boost_dis_q || s_bsh || !s_dbok)
            state_d = lbs_pkg::ST_BURN;
          else
            state_d = lbs_pkg::ST_BOOST;
        end
        else if (unlit_tmo)
          state_d = fail_ign ? lbs_pkg::ST_HOLD : lbs_pkg::ST_PWRDN;
      lbs_pkg::ST_BOOST:
        if (s_dblo || s_bsh)
          state_d = lbs_pkg::ST_BURN;
        else if (s_tend || (b_ev && bcnt_q == 6'(lbs_pkg::BOOST_PULSES - 1)))
          state_d = lbs_pkg::ST_TRANS;
      lbs_pkg::ST_TRANS:
        if (s_dblo || s_bsh)
          state_d = lbs_pkg::ST_BURN;
        else if (p_ev && pcnt_q == 6'(lbs_pkg::TRANS_PULSES - 1))
          state_d = lbs_pkg::ST_BURN;
      lbs_pkg::ST_BURN:
        state_d = lbs_pkg::ST_BURN;
      lbs_pkg::ST_HOLD:
        if (!wait_top_q && s_rel)
          state_d = lbs_pkg::ST_STARTUP;
      lbs_pkg::ST_PWRDN:
        state_d = lbs_pkg::ST_PWRDN;
      default:
        state_d = lbs_pkg::ST_STARTUP;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      state_q <= lbs_pkg::ST_STARTUP;
    else
      state_q <= state_d;
  end

  // Preheat timer counts pulses in preheat, ignition window and transition
  always_ff @(posedge clk)
  begin
    if (srst || state_d != state_q)
      pcnt_q <= '0;
    else if (p_ev)
      pcnt_q <= pcnt_q + 6'h01;
  end

  // Boost timer idles at zero outside boost
  always_ff @(posedge clk)
  begin
    if (srst || state_q != lbs_pkg::ST_BOOST)
      bcnt_q <= '0;
    else if (b_ev)
      bcnt_q <= bcnt_q + 6'h01;
  end

  // Attempt counter survives hold; only cleared by supply reset
  always_ff @(posedge clk)
  begin
    if (srst)
      att_q <= '0;
    else if (unlit_tmo && !abort && !s_ign)
      att_q <= att_q + 2'h1;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      boost_dis_q <= 1'b0;
    else if (s_bsh)
      boost_dis_q <= 1'b1;
  end

  // Failed ignition waits for the ramp top before hold timing begins
  always_ff @(posedge clk)
  begin
    if (srst)
      wait_top_q <= 1'b0;
    else if (state_q == lbs_pkg::ST_IGNITE && state_d == lbs_pkg::ST_HOLD && !abort)
      wait_top_q <= 1'b1;
    else if (s_ptop)
      wait_top_q <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      hold_latch <= 1'b0;
    else if (state_d == lbs_pkg::ST_HOLD)
      hold_latch <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Set point ratio: 5 steps of 0.1 from 1.5 to 1.0 during the 32-pulse transition
  logic [4:0] step_q;
  always_ff @(posedge clk)
  begin
    if (srst)
      boost_act_q <= 1'b0;
    else
      boost_act_q <= (state_d == lbs_pkg::ST_BOOST) && s_dbok;
  end

  always_ff @(posedge clk)
  begin
    if (srst || state_q != lbs_pkg::ST_TRANS)
      step_q <= '0;
    else if (p_ev && pcnt_q[0] && step_q < 5'(lbs_pkg::TRANS_STEPS))
      step_q <= step_q + 5'h01;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      current_ratio <= lbs_pkg::RATIO_BURN;
    else if (state_d == lbs_pkg::ST_BOOST && s_dbok && !s_dblo)
      current_ratio <= lbs_pkg::RATIO_BOOST;
    else if (state_d == lbs_pkg::ST_TRANS)
      current_ratio <= lbs_pkg::RATIO_BOOST - 5'((32'(step_q) + 32'h2) / 32'h3);
    else
      current_ratio <= lbs_pkg::RATIO_BURN;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      freq_ratio <= lbs_pkg::FRATIO_MIN;
    else if (boost_dis_q || s_bsh)
      freq_ratio <= lbs_pkg::FRATIO_NOBST;
    else if (state_d == lbs_pkg::ST_BOOST || state_d == lbs_pkg::ST_TRANS)
      freq_ratio <= lbs_pkg::FRATIO_BST;
    else
      freq_ratio <= lbs_pkg::FRATIO_MIN;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ignite_sweep            <= 1'b0;
      transconductance_amp_en <= 1'b0;
      state_out               <= lbs_pkg::ST_STARTUP;
    end
    else
    begin
      ignite_sweep            <= state_d == lbs_pkg::ST_IGNITE;
      transconductance_amp_en <= (state_d == lbs_pkg::ST_BURN ||
                                  state_d == lbs_pkg::ST_BOOST ||
                                  state_d == lbs_pkg::ST_TRANS) && s_rms;
      state_out               <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gate drive: each sawtooth period is one half bridge cycle
  logic run_d;
  logic phase_q;
  logic [15:0] gap_q;
  assign run_d = state_d inside {lbs_pkg::ST_PREHEAT, lbs_pkg::ST_IGNITE,
                 lbs_pkg::ST_BOOST, lbs_pkg::ST_TRANS, lbs_pkg::ST_BURN};

  always_ff @(posedge clk)
  begin
    if (srst)
      osc_run <= 1'b0;
    else
      osc_run <= run_d;
  end

  always_ff @(posedge clk)
  begin
    if (srst || !osc_run)
      phase_q <= 1'b0;
    else if (o_ev)
      phase_q <= ~phase_q;
  end

  always_ff @(posedge clk)
  begin
    if (srst || !osc_run || o_ev)
      gap_q <= 16'(NO_CYCLES);
    else if (gap_q != 16'h0000)
      gap_q <= gap_q - 16'h0001;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      high_side_switch <= 1'b0;
      low_side_switch  <= 1'b0;
    end
    else if (!osc_run)
    begin
      high_side_switch <= 1'b0;
      low_side_switch  <= state_q != lbs_pkg::ST_PWRDN;
    end
    else
    begin
      high_side_switch <= phase_q && gap_q == 16'h0000 && !o_ev;
      low_side_switch  <= !phase_q && gap_q == 16'h0000 && !o_ev;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_no_overlap: assert property (@(posedge clk) disable iff (srst)
    !(high_side_switch && low_side_switch)) else $error("both switches on");
  a_hold_drive: assert property (@(posedge clk) disable iff (srst)
    state_q == lbs_pkg::ST_HOLD |=> !high_side_switch) else $error("high side in hold");
  a_hold_latch: assert property (@(posedge clk) disable iff (srst)
    state_q == lbs_pkg::ST_HOLD |-> hold_latch) else $error("hold latch clear");
  a_attempt_max: assert property (@(posedge clk) disable iff (srst)
    att_q <= 2'h2) else $error("attempt counter overran");
  a_ignite_burn: assert property (@(posedge clk) disable iff (srst)
    state_q == lbs_pkg::ST_IGNITE && s_ign && !abort && s_tbp |=> state_q == lbs_pkg::ST_BURN)
    else $error("hot die did not skip boost");
  a_boost_ratio: assert property (@(posedge clk) disable iff (srst)
    state_q == lbs_pkg::ST_BOOST && $past(state_q) == lbs_pkg::ST_BOOST && s_dbok && !s_dblo
    |=> current_ratio == lbs_pkg::RATIO_BOOST) else $error("boost ratio wrong");
  a_tend_trans: assert property (@(posedge clk) disable iff (srst)
    state_q == lbs_pkg::ST_BOOST && s_tend && !s_dblo |=> state_q == lbs_pkg::ST_TRANS)
    else $error("boost end temperature ignored");
  a_abort_hold: assert property (@(posedge clk) disable iff (srst)
    state_q == lbs_pkg::ST_PREHEAT && abort |=> state_q == lbs_pkg::ST_HOLD && $stable(att_q))
    else $error("abort not to hold");
  a_shorted_cb: assert property (@(posedge clk) disable iff (srst)
    boost_dis_q |-> state_q != lbs_pkg::ST_BOOST) else $error("boost while disabled");
  a_burn_ratio: assert property (@(posedge clk) disable iff (srst)
    state_q == lbs_pkg::ST_BURN && $past(state_q) == lbs_pkg::ST_BURN
    |-> current_ratio == lbs_pkg::RATIO_BURN) else $error("burn ratio wrong");
endmodule
`default_nettype wire

// file: bench/lbs_bridge.sv
// Half-bridge power stage model driven by the two gate outputs
`timescale 1ns/1ps
`default_nettype none
module lbs_bridge (
  input  wire logic       clk,
  input  wire logic       high_side_switch,
  input  wire logic       low_side_switch,
  output logic            shoot_thru,
  output logic [7:0]      n_rise
);
  logic node_q;
  initial
  begin
    shoot_thru = 1'b0;
    n_rise = 8'h00;
    node_q = 1'b0;
  end
  // Both switches on shorts the supply; the flag is sticky so a glitch is not missed
  always @(posedge clk)
  begin
    if (high_side_switch && low_side_switch)
      shoot_thru <= 1'b1;
    if (high_side_switch && !low_side_switch && !node_q)
      n_rise <= n_rise + 8'h01;
    if (high_side_switch != low_side_switch)
      node_q <= high_side_switch;
  end
endmodule
`default_nettype wire

// file: bench/lbs_seq_bench.sv
// Self-checking bench for the lamp ballast sequencer
`timescale 1ns/1ps
`default_nettype none
module lbs_seq_bench;
  logic clk, srst, vdd_start_ok, vdd_stop_low, dim_start_ok, dim_off_low;
  logic dim_boost_ok, dim_boost_low, preheat_cap_max, preheat_cap_pulse;
  logic preheat_cap_top, hold_release_level, boost_cap_pulse, boost_cap_short;
  logic lamp_ignited, boost_bypass_temp, boost_end_temp, lamp_rms_at_ref;
  logic osc_saw_pulse, high_side_switch, low_side_switch, osc_run, ignite_sweep;
  logic transconductance_amp_en, hold_latch, shoot_thru;
  logic [4:0] current_ratio;
  logic [5:0] freq_ratio;
  logic [7:0] state_out, n_rise;
  int         n_errors = 0;
  int         tests_run = 0;
  lbs_seq #(.NO_CYCLES(2)) DUT (.clk(clk), .srst(srst), .vdd_start_ok(vdd_start_ok),
    .vdd_stop_low(vdd_stop_low), .dim_start_ok(dim_start_ok), .dim_off_low(dim_off_low),
    .dim_boost_ok(dim_boost_ok), .dim_boost_low(dim_boost_low),
    .preheat_cap_max(preheat_cap_max), .preheat_cap_pulse(preheat_cap_pulse),
    .preheat_cap_top(preheat_cap_top), .hold_release_level(hold_release_level),
    .boost_cap_pulse(boost_cap_pulse), .boost_cap_short(boost_cap_short),
    .lamp_ignited(lamp_ignited), .boost_bypass_temp(boost_bypass_temp),
    .boost_end_temp(boost_end_temp), .lamp_rms_at_ref(lamp_rms_at_ref),
    .osc_saw_pulse(osc_saw_pulse), .high_side_switch(high_side_switch),
    .low_side_switch(low_side_switch), .osc_run(osc_run), .ignite_sweep(ignite_sweep),
    .transconductance_amp_en(transconductance_amp_en), .current_ratio(current_ratio),
    .freq_ratio(freq_ratio), .hold_latch(hold_latch), .state_out(state_out));
  lbs_bridge u_bridge (.clk(clk), .high_side_switch(high_side_switch),
    .low_side_switch(low_side_switch), .shoot_thru(shoot_thru), .n_rise(n_rise));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bounded wait, then the state itself is compared
  task automatic wait_st(input logic [7:0] e);
    int i;
    i = 0;
    while (state_out !== e && i < 300)
    begin
      tick(1);
      i++;
    end
    chk(state_out, e);
  endtask
  task automatic set_p(input int which, input logic v);
    case (which)
      0: preheat_cap_pulse = v;
      1: boost_cap_pulse = v;
      2: osc_saw_pulse = v;
      default: preheat_cap_top = v;
    endcase
  endtask
  // Six cycles each way so the synchroniser never drops a pulse
  task automatic pulse(input int which, input int n);
    repeat (n)
    begin
      set_p(which, 1'b1);
      tick(6);
      set_p(which, 1'b0);
      tick(6);
    end
  endtask
  task automatic do_reset;
    srst = 1'b1;
    {vdd_start_ok, vdd_stop_low, dim_start_ok, dim_off_low, dim_boost_ok} = 5'h00;
    {dim_boost_low, preheat_cap_max, preheat_cap_pulse, preheat_cap_top} = 4'h0;
    {hold_release_level, boost_cap_pulse, boost_cap_short, lamp_ignited} = 4'h0;
    {boost_bypass_temp, boost_end_temp, lamp_rms_at_ref, osc_saw_pulse} = 4'h0;
    tick(10);
    srst = 1'b0;
    tick(2);
    chk(state_out, 8'h01);
    chk({high_side_switch, low_side_switch}, 8'h01);
    chk(current_ratio, 8'h0A);
    chk(freq_ratio, 8'h19);
    chk(hold_latch, 8'h00);
  endtask
  task automatic to_ignite;
    vdd_start_ok = 1'b1;
    dim_start_ok = 1'b1;
    preheat_cap_max = 1'b1;
    wait_st(8'h02);
    tick(2);
    chk(osc_run, 8'h01);
    pulse(0, 7);
    chk(state_out, 8'h02);
    pulse(0, 1);
    wait_st(8'h04);
    chk(ignite_sweep, 8'h01);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_boost;
    logic [7:0] r0;
    do_reset;
    to_ignite;
    r0 = n_rise;
    pulse(2, 4);
    chk(n_rise - r0, 8'h02);
    chk(shoot_thru, 8'h00);
    dim_boost_ok = 1'b1;
    lamp_ignited = 1'b1;
    wait_st(8'h08);
    chk(current_ratio, 8'h0F);
    chk(freq_ratio, 8'h2E);
    pulse(1, 62);
    chk(state_out, 8'h08);
    pulse(1, 1);
    wait_st(8'h10);
    pulse(0, 31);
    chk(state_out, 8'h10);
    pulse(0, 1);
    wait_st(8'h20);
    chk(current_ratio, 8'h0A);
    lamp_rms_at_ref = 1'b1;
    tick(8);
    chk(transconductance_amp_en, 8'h01);
  endtask
  // Hot die, shorted boost pin and low dim level each skip boost
  task automatic t_skip;
    for (int k = 0; k < 3; k++)
    begin
      do_reset;
      to_ignite;
      boost_bypass_temp = (k == 0);
      boost_cap_short = (k == 1);
      dim_boost_ok = (k != 2);
      lamp_ignited = 1'b1;
      wait_st(8'h20);
      if (k == 1)
        chk(freq_ratio, 8'h1A);
    end
  endtask
  task automatic t_boost_exit;
    for (int k = 0; k < 2; k++)
    begin
      do_reset;
      to_ignite;
      dim_boost_ok = 1'b1;
      lamp_ignited = 1'b1;
      wait_st(8'h08);
      boost_end_temp = (k == 0);
      dim_boost_ok = (k == 0);
      dim_boost_low = (k == 1);
      wait_st(k ? 8'h20 : 8'h10);
      chk(current_ratio, k ? 8'h0A : 8'h0F);
    end
  endtask
  task automatic t_fail;
    do_reset;
    to_ignite;
    pulse(0, 1);
    chk(state_out, 8'h04);
    pulse(0, 1);
    wait_st(8'h40);
    chk(hold_latch, 8'h01);
    chk(osc_run, 8'h00);
    chk({high_side_switch, low_side_switch}, 8'h01);
    preheat_cap_max = 1'b0;
    hold_release_level = 1'b1;
    tick(20);
    chk(state_out, 8'h40);
    pulse(3, 1);
    wait_st(8'h01);
    hold_release_level = 1'b0;
    to_ignite;
    pulse(0, 2);
    wait_st(8'h80);
    chk({high_side_switch, low_side_switch}, 8'h00);
  endtask
  // A dim or supply drop must not use up an ignition attempt
  task automatic t_abort;
    for (int k = 0; k < 3; k++)
    begin
      do_reset;
      if (k < 2)
        to_ignite;
      else
      begin
        {vdd_start_ok, dim_start_ok, preheat_cap_max} = 3'h7;
        wait_st(8'h02);
        pulse(0, 3);
      end
      vdd_stop_low = (k == 1);
      dim_off_low = (k != 1);
      wait_st(8'h40);
      {preheat_cap_max, vdd_stop_low, dim_off_low} = 3'h0;
      hold_release_level = 1'b1;
      wait_st(8'h01);
      hold_release_level = 1'b0;
      to_ignite;
      pulse(0, 2);
      wait_st(8'h40);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("Comparisons: %0d  mismatches: %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    repeat (60000) @(posedge clk);
    n_errors++;
    summarize;
  end
  initial
  begin
    do_reset;
    t_boost;
    t_skip;
    t_boost_exit;
    t_fail;
    t_abort;
    summarize;
  end
endmodule
`default_nettype wire
